// File: tb/rbsu_dev_model.sv
// Behavioural model of the secured RAM bank decoder
`timescale 1ns/10ps
`default_nettype none
module rbsu_dev_model #(
   parameter logic [63:0] USER_PAT = 64'h5a3c_96e1_0f7b_c248,
   parameter logic [63:0] ID_PAT   = 64'h1357_9bdf_2468_ace0,
   parameter logic        BATT_LOW = 1'b0   // Weak backup cell, off in these runs
) (
   input  wire logic       rst_n_i,
   input  wire logic       supply_ok_i,
   input  wire logic       ce_n_i,
   input  wire logic       we_n_i,
   input  wire logic       rd_n_i,
   input  wire logic [1:0] bank_i,
   input  wire logic       host_dq_i,
   input  wire logic       host_oe_i,
   output logic            line_o,
   output logic [3:0]      ram_select_out_o
);
   localparam int P_IDLE = 0;
   localparam int P_CODE = 1;
   localparam int P_ID   = 2;
   localparam int P_OPEN = 3;
   localparam int P_DEAD = 4;
   int          phase  = P_IDLE;
   int          cnt    = 0;
   logic [63:0] code_r = '0;   // Write-only, never put on the line
   logic [3:0]  ram    = 4'h0;
   logic        hold   = 1'b0;
   logic [3:0]  held   = 4'hf;
   logic        last   = 1'b0;
   logic        dev_oe;
   logic        dev_dq;
   logic        drv;
   logic        val;
   wire         wr_on  = ~ce_n_i & ~we_n_i;
   wire         rd_on  = ~ce_n_i & ~rd_n_i;
   int          up_cyc = 0;
   wire         blk    = BATT_LOW && (up_cyc == 1);

   always @(negedge rst_n_i) begin
      phase = P_CODE;
      cnt = 0;
   end
   always @(negedge supply_ok_i) begin
      held = ram_select_out_o;
      hold = ~ce_n_i;
      phase = P_IDLE;
   end
   always @(posedge ce_n_i) hold = 1'b0;
   // Cycles since power came back; a weak cell loses the second one
   always @(posedge supply_ok_i) up_cyc = 0;
   always @(posedge ce_n_i) up_cyc++;
   // Bit taken where the first strobe rises
   always @(negedge wr_on) begin
      if (phase == P_CODE) begin
         code_r[cnt] = host_dq_i;
         cnt++;
         if (cnt == 64) begin
            phase = (code_r == USER_PAT) ? P_ID : P_DEAD;
            cnt = 0;
         end
      end else if (phase == P_OPEN && supply_ok_i && !blk) begin
         ram[bank_i] = host_dq_i;
      end
   end
   always @(negedge rd_on) begin
      if (phase == P_ID) begin
         cnt++;
         if (cnt == 64) phase = P_OPEN;
      end else if (phase != P_OPEN) begin
         phase = P_CODE;
         cnt = 0;
      end
   end
   assign dev_oe = rd_on && (phase == P_ID || phase == P_OPEN);
   assign dev_dq = (phase == P_ID) ? ID_PAT[cnt] : ram[bank_i];
   always_comb begin
      if (ce_n_i) ram_select_out_o = 4'hf;
      else if (hold) ram_select_out_o = held;
      else if (blk) ram_select_out_o = 4'hf;
      else if (supply_ok_i && phase == P_OPEN) ram_select_out_o = ~(4'h1 << bank_i);
      else ram_select_out_o = 4'hf;
   end
   // No pull on the line: a released line shows the inverse, not a stale copy
   assign drv = host_oe_i | dev_oe;
   assign val = host_oe_i ? host_dq_i : dev_dq;
   always @(drv or val) if (drv) last = val;
   assign line_o = drv ? val : ~last;
endmodule : rbsu_dev_model
`default_nettype wire

// File: tb/test_rbsu_host.sv
// Self-checking bench for the RAM bank unlock host controller
`include "rbsu_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module test_rbsu_host
   import rbsu_pkg::*;
;
   localparam logic [63:0] USER_PAT = 64'h5a3c_96e1_0f7b_c248;
   localparam logic [63:0] ID_PAT   = 64'h1357_9bdf_2468_ace0;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        req = 1'b0;
   logic        use_rst = 1'b0;
   logic [63:0] code = '0;
   logic        cmd_valid = 1'b0;
   rbsu_cmd_t   cmd = '0;
   logic        supply_ok = 1'b1;
   logic        busy, unlocked, done, cmd_ready, rdata, rdata_valid;
   logic [63:0] id;
   logic        dev_rst_n, ce_n, we_n, rd_n, dq_o, dq_oe, dq_line;
   logic [1:0]  bank;
   logic [3:0]  sel_n;
   logic [3:0]  mem = 4'h0;
   logic        exp_q[$];
   logic [1:0]  bk_q[$];
   logic        ce_n_d = 1'b1;
   logic        bench_open = 1'b0;
   logic        saw_full = 1'b0;
   int          error_cnt = 0;
   int          checks = 0;
   int          cyc = 0;
   int          seed = 32'h01b4;
   int          r;

   rbsu_host rbsu_host_inst (.CLK_I(clk), .RST_I(rst), .UNLOCK_REQ_I(req), .USE_RESET_I(use_rst),
      .CODE_I(code), .BUSY_O(busy), .UNLOCKED_O(unlocked), .DONE_O(done), .ID_O(id),
      .CMD_VALID_I(cmd_valid), .CMD_I(cmd), .CMD_READY_O(cmd_ready), .RDATA_O(rdata),
      .RDATA_VALID_O(rdata_valid), .DEV_RST_N_O(dev_rst_n), .DEV_CE_N_O(ce_n),
      .DEV_WE_N_O(we_n), .DEV_RD_N_O(rd_n), .DEV_BANK_O(bank), .DEV_DQ_O(dq_o),
      .DEV_DQ_OE_O(dq_oe), .DEV_DQ_I(dq_line));
   rbsu_dev_model #(.USER_PAT(USER_PAT), .ID_PAT(ID_PAT)) rbsu_dev_model_inst (
      .rst_n_i(dev_rst_n), .supply_ok_i(supply_ok), .ce_n_i(ce_n), .we_n_i(we_n),
      .rd_n_i(rd_n), .bank_i(bank), .host_dq_i(dq_o), .host_oe_i(dq_oe),
      .line_o(dq_line), .ram_select_out_o(sel_n));

   always #5 clk = ~clk;

   task automatic chk1(input logic got, input logic exp, input string what);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
      end
   endtask : chk1
   task automatic chk4(input logic [3:0] got, input logic [3:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk4
   task automatic chk64(input logic [63:0] got, input logic [63:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk64
   task automatic end_sim;
      $display("Counts: checks %0d, mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_sim

   // Whole unlock; the bench only trusts the bank after a matching code
   task automatic unlock(input logic [63:0] c, input logic by_rst);
      int n;
      n = 0;
      @(negedge clk);
      req = 1'b1;
      use_rst = by_rst;
      code = c;
      bench_open = 1'b0;
      @(negedge clk);
      req = 1'b0;
      while (done !== 1'b1 && n < 8000) begin
         @(negedge clk);
         n++;
      end
      chk1(done, 1'b1, "unlock finished");
      @(negedge clk);
      chk1(unlocked, 1'b1, "unlocked flag");
      if (c === USER_PAT) chk64(id, ID_PAT, "identity word");
      else chk1(id === ID_PAT, 1'b0, "identity after bad code");
      bench_open = (c === USER_PAT);
   endtask : unlock

   // Valid dropped while refused, so a held command is never pushed twice
   task automatic push(input logic w, input logic [1:0] bk, input logic d);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 200) begin
         cmd_valid = 1'b0;
         saw_full = 1'b1;
         @(negedge clk);
         n++;
      end
      cmd_valid = 1'b1;
      cmd = {w, bk, d};
      bk_q.push_back(bk);
      if (!w) exp_q.push_back(mem[bk]);
      else if (bench_open) mem[bk] = d;
      @(negedge clk);
   endtask : push

   task automatic drain;
      int n;
      int idle;
      n = 0;
      idle = 0;
      cmd_valid = 1'b0;
      while (idle < 40 && n < 3000) begin
         @(negedge clk);
         idle = (busy === 1'b0) ? idle + 1 : 0;
         n++;
      end
      chk1(exp_q.size() == 0, 1'b1, "reads answered");
   endtask : drain

   always @(negedge clk) begin
      cyc++;
      if (!rst && rdata_valid === 1'b1) begin
         if (exp_q.size() == 0) chk1(1'b1, 1'b0, "spare read");
         else chk1(rdata, exp_q.pop_front(), "read data");
      end
      if (!bench_open) chk4(sel_n, 4'hf, "selects while locked");
      else if (!ce_n && supply_ok && bk_q.size() > 0) chk4(sel_n, ~(4'h1 << bk_q[0]), "bank decode");
      // Expected bank comes from the command, not from the pins
      if (unlocked === 1'b1 && ce_n === 1'b1 && ce_n_d === 1'b0 && bk_q.size() > 0) bk_q.delete(0);
      ce_n_d = ce_n;
      if (cyc > 40000) begin
         error_cnt++;
         $display("unexpected at %0t: run too long", $time);
         end_sim();
      end
   end

   initial begin
      repeat (6) @(negedge clk);
      rst = 1'b0;
      unlock(USER_PAT, 1'b0);
      $display("test dummy start unlock finished");
      for (int k = 0; k < 16; k++) begin
         r = $random(seed);
         push(r[0], r[2:1], r[3]);
      end
      drain();
      chk1(saw_full, 1'b1, "command queue refused");
      $display("test memory traffic finished");
      for (int f = 0; f < 2; f++) begin
         unlock(USER_PAT ^ (64'h1 << (f * 63)), 1'b1);
         push(1'b1, 2'd1, ~mem[1]);
         drain();
      end
      unlock(USER_PAT, 1'b1);
      push(1'b0, 2'd1, 1'b0);
      drain();
      $display("test bad code finished");
      supply_ok = 1'b0;
      bench_open = 1'b0;
      push(1'b1, 2'd2, ~mem[2]);
      drain();
      supply_ok = 1'b1;
      unlock(USER_PAT, 1'b0);
      push(1'b0, 2'd2, 1'b0);
      drain();
      $display("test supply fail finished");
      end_sim();
   end
endmodule : test_rbsu_host
`default_nettype wire

// File: verilog/rbsu_cfg.svh
// Timing counts and sizes for the RAM bank unlock host controller
`ifndef RBSU_CFG_SVH
`define RBSU_CFG_SVH

`define RBSU_CLK_NS        10
`define RBSU_CODE_BITS     64
`define RBSU_LAST_BIT      (`RBSU_CODE_BITS - 1)
`define RBSU_FIFO_DEPTH    4

`define RBSU_T_RST_NS      200
`define RBSU_T_AS_NS       20
`define RBSU_T_WP_NS       170
`define RBSU_T_WC_NS       250
`define RBSU_T_CO_NS       200
`define RBSU_T_RR_NS       50
`define RBSU_T_CE_MAX_NS   1500

`define RBSU_CEIL_CYC(ns)  (((ns) + `RBSU_CLK_NS - 1) / `RBSU_CLK_NS)
`define RBSU_RST_CYC       `RBSU_CEIL_CYC(`RBSU_T_RST_NS)
`define RBSU_SET_CYC       `RBSU_CEIL_CYC(`RBSU_T_AS_NS)
`define RBSU_WR_ACT_CYC    `RBSU_CEIL_CYC(`RBSU_T_WP_NS)
`define RBSU_WR_REC_CYC    `RBSU_CEIL_CYC(`RBSU_T_WC_NS - `RBSU_T_WP_NS)
`define RBSU_SYNC_CYC      3
`define RBSU_RD_ACT_CYC    (`RBSU_CEIL_CYC(`RBSU_T_CO_NS) + `RBSU_SYNC_CYC)
`define RBSU_RD_REC_CYC    `RBSU_CEIL_CYC(`RBSU_T_RR_NS)
`define RBSU_CE_MAX_CYC    (`RBSU_T_CE_MAX_NS / `RBSU_CLK_NS)

`endif

// File: verilog/rbsu_fifo.sv
// Small valid/ready FIFO for memory commands
`timescale 1ns/10ps
`default_nettype none
module rbsu_fifo #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 4
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
   logic [CW-1:0]    cnt_r, cnt_nxt;
   logic             room_r, room_nxt, empty_r, empty_nxt;
   logic             push, pop;

   assign push        = in_valid_i && room_r;
   assign pop         = out_ready_i && !empty_r;
   // Ready straight from a flop, no inverter on the way out
   assign in_ready_o  = room_r;
   assign out_valid_o = !empty_r;
   assign out_data_o  = mem_r[rp_r];

   always_comb begin
      wp_nxt  = wp_r;
      rp_nxt  = rp_r;
      cnt_nxt = cnt_r;
      if (push) begin
         // Wrap explicitly so any depth works, not only powers of two
         wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
      end
      if (pop) begin
         rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
      end
      if (push && !pop) begin
         cnt_nxt = cnt_r + CW'(1);
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - CW'(1);
      end
      room_nxt  = (cnt_nxt != CW'(DEPTH));
      empty_nxt = (cnt_nxt == '0);
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wp_r    <= '0;
         rp_r    <= '0;
         cnt_r   <= '0;
         room_r  <= 1'b1;
         empty_r <= 1'b1;
      end else begin
         wp_r    <= wp_nxt;
         rp_r    <= rp_nxt;
         cnt_r   <= cnt_nxt;
         room_r  <= room_nxt;
         empty_r <= empty_nxt;
      end
   end

   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge clk_i) begin
         if (push && wp_r == AW'(i)) begin
            mem_r[i] <= in_data_i;
         end
      end
   end

endmodule : rbsu_fifo
`default_nettype wire

// File: verilog/rbsu_host.sv
// Host controller that unlocks and then drives a secured battery-backed RAM bank
// Function
// - Start each unlock with a dummy read or a reset pulse of 200 ns.
// - Write the 64-bit access code, one bit per write cycle on the data line.
// - Host performs the 64 identity reads back to back, no write between.
// - Host keeps every chip select low pulse at most 1.5 us.
`include "rbsu_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module rbsu_host
   import rbsu_pkg::*;
(
   input  wire logic                       CLK_I,
   input  wire logic                       RST_I,
   input  wire logic                       UNLOCK_REQ_I,
   input  wire logic                       USE_RESET_I,
   input  wire logic [`RBSU_CODE_BITS-1:0] CODE_I,
   output logic                            BUSY_O,
   output logic                            UNLOCKED_O,
   output logic                            DONE_O,
   output logic [`RBSU_CODE_BITS-1:0]      ID_O,
   input  wire logic                       CMD_VALID_I,
   input  wire rbsu_cmd_t                  CMD_I,
   output logic                            CMD_READY_O,
   output logic                            RDATA_O,
   output logic                            RDATA_VALID_O,
   output logic                            DEV_RST_N_O,
   output logic                            DEV_CE_N_O,
   output logic                            DEV_WE_N_O,
   output logic                            DEV_RD_N_O,
   output logic [1:0]                      DEV_BANK_O,
   output logic                            DEV_DQ_O,
   output logic                            DEV_DQ_OE_O,
   input  wire logic                       DEV_DQ_I
);
   localparam int CODE_W = `RBSU_CODE_BITS;

   rbsu_state_t         state_r, state_nxt;
   logic [7:0]          cnt_r, cnt_nxt;
   logic [5:0]          bit_r, bit_nxt;
   logic [CODE_W-1:0]   code_r, code_nxt, id_r, id_nxt;
   rbsu_cmd_t           cur_r, cur_nxt;
   rbsu_pins_t          pin_r, pin_nxt;
   logic                unl_r, unl_nxt, done_r, done_nxt, busy_r, busy_nxt;
   logic                rdat_r, rdat_nxt, rval_r, rval_nxt;
   logic                dq_m_r, dq_s_r;
   logic                fifo_valid, fifo_pop;
   rbsu_cmd_t           fifo_data;
   logic                in_cyc, is_rd, act, sample, cyc_end;
   logic [7:0]          act_len, rec_len;

   // Commands wait here until the bank is unlocked; full FIFO stalls the source
   rbsu_fifo #(
      .WIDTH ($bits(rbsu_cmd_t)),
      .DEPTH (`RBSU_FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (CLK_I),
      .rst_i       (RST_I),
      .in_valid_i  (CMD_VALID_I),
      .in_ready_o  (CMD_READY_O),
      .in_data_i   (CMD_I),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_pop),
      .out_data_o  (fifo_data)
   );

   // Data line is asynchronous to CLK_I
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         dq_m_r <= 1'b0;
         dq_s_r <= 1'b0;
      end else begin
         dq_m_r <= DEV_DQ_I;
         dq_s_r <= dq_m_r;
      end
   end

   always_comb begin
      in_cyc  = (state_r == S_DUMMY) || (state_r == S_CODE) ||
                (state_r == S_ID) || (state_r == S_MEM);
      is_rd   = (state_r == S_DUMMY) || (state_r == S_ID) ||
                ((state_r == S_MEM) && !cur_r.wr);
      act_len = is_rd ? 8'(`RBSU_RD_ACT_CYC) : 8'(`RBSU_WR_ACT_CYC);
      rec_len = is_rd ? 8'(`RBSU_RD_REC_CYC) : 8'(`RBSU_WR_REC_CYC);
      // Active window fits well inside the select pulse limit
      act     = in_cyc && (cnt_r >= 8'(`RBSU_SET_CYC)) &&
                (cnt_r < 8'(`RBSU_SET_CYC) + act_len);
      // Sample late so access time plus the synchroniser has elapsed
      sample  = in_cyc && is_rd && (cnt_r == 8'(`RBSU_SET_CYC) + act_len - 8'h01);
      cyc_end = in_cyc && (cnt_r == 8'(`RBSU_SET_CYC) + act_len + rec_len - 8'h01);
   end

   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r + 8'h01;
      bit_nxt   = bit_r;
      code_nxt  = code_r;
      id_nxt    = id_r;
      cur_nxt   = cur_r;
      unl_nxt   = unl_r;
      done_nxt  = 1'b0;
      rdat_nxt  = rdat_r;
      rval_nxt  = 1'b0;
      fifo_pop  = 1'b0;
      unique case (state_r)
         S_IDLE, S_OPEN: begin
            cnt_nxt = '0;
            if (UNLOCK_REQ_I) begin
               code_nxt  = CODE_I;
               bit_nxt   = '0;
               unl_nxt   = 1'b0;
               state_nxt = USE_RESET_I ? S_RST : S_DUMMY;
            end else if (state_r == S_OPEN && fifo_valid) begin
               cur_nxt   = fifo_data;
               fifo_pop  = 1'b1;
               state_nxt = S_MEM;
            end
         end
         S_RST: begin
            if (cnt_r == 8'(`RBSU_RST_CYC - 1)) begin
               cnt_nxt   = '0;
               state_nxt = S_CODE;
            end
         end
         S_DUMMY: begin
            if (cyc_end) begin
               cnt_nxt   = '0;
               state_nxt = S_CODE;
            end
         end
         S_CODE: begin
            if (cyc_end) begin
               cnt_nxt = '0;
               bit_nxt = bit_r + 6'h01;
               // No read is issued until all code bits are written
               if (bit_r == 6'(`RBSU_LAST_BIT)) begin
                  state_nxt = S_ID;
               end
            end
         end
         S_ID: begin
            if (sample) begin
               id_nxt[bit_r] = dq_s_r;
            end
            if (cyc_end) begin
               cnt_nxt = '0;
               bit_nxt = bit_r + 6'h01;
               if (bit_r == 6'(`RBSU_LAST_BIT)) begin
                  unl_nxt   = 1'b1;
                  done_nxt  = 1'b1;
                  state_nxt = S_OPEN;
               end
            end
         end
         S_MEM: begin
            if (sample) begin
               rdat_nxt = dq_s_r;
            end
            if (cyc_end) begin
               cnt_nxt   = '0;
               rval_nxt  = !cur_r.wr;
               state_nxt = S_OPEN;
            end
         end
      endcase
      busy_nxt = (state_nxt != S_IDLE) && (state_nxt != S_OPEN);
   end

   always_comb begin
      pin_nxt       = pin_r;
      pin_nxt.rst_n = !(state_nxt == S_RST);
      pin_nxt.ce_n  = !act;
      pin_nxt.we_n  = !(act && !is_rd);
      // Select and write rise together, so the bit is taken at that edge
      pin_nxt.rd_n  = !(act && is_rd);
      pin_nxt.dq_oe = in_cyc && !is_rd;
      if (state_r == S_CODE) begin
         pin_nxt.dq   = code_r[bit_r];
         pin_nxt.bank = 2'h0;
      end else if (state_r == S_MEM) begin
         pin_nxt.dq   = cur_r.dat;
         pin_nxt.bank = cur_r.bank;
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         state_r <= S_IDLE;
         cnt_r   <= '0;
         bit_r   <= '0;
         code_r  <= '0;
         id_r    <= '0;
         cur_r   <= '0;
         unl_r   <= 1'b0;
         done_r  <= 1'b0;
         busy_r  <= 1'b0;
         rdat_r  <= 1'b0;
         rval_r  <= 1'b0;
         pin_r   <= '{rst_n: 1'b1, ce_n: 1'b1, we_n: 1'b1, rd_n: 1'b1,
                      bank: 2'h0, dq: 1'b0, dq_oe: 1'b0};
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         bit_r   <= bit_nxt;
         code_r  <= code_nxt;
         id_r    <= id_nxt;
         cur_r   <= cur_nxt;
         unl_r   <= unl_nxt;
         done_r  <= done_nxt;
         busy_r  <= busy_nxt;
         rdat_r  <= rdat_nxt;
         rval_r  <= rval_nxt;
         pin_r   <= pin_nxt;
      end
   end

   assign BUSY_O        = busy_r;
   assign UNLOCKED_O    = unl_r;
   assign DONE_O        = done_r;
   assign ID_O          = id_r;
   assign RDATA_O       = rdat_r;
   assign RDATA_VALID_O = rval_r;
   assign DEV_RST_N_O   = pin_r.rst_n;
   assign DEV_CE_N_O    = pin_r.ce_n;
   assign DEV_WE_N_O    = pin_r.we_n;
   assign DEV_RD_N_O    = pin_r.rd_n;
   assign DEV_BANK_O    = pin_r.bank;
   assign DEV_DQ_O      = pin_r.dq;
   assign DEV_DQ_OE_O   = pin_r.dq_oe;

   // Helper counters for pulse widths
   logic [7:0] ce_low_r, rst_low_r;
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ce_low_r  <= '0;
         rst_low_r <= '0;
      end else begin
         ce_low_r  <= pin_r.ce_n ? 8'h00 : ce_low_r + 8'h01;
         rst_low_r <= pin_r.rst_n ? 8'h00 : rst_low_r + 8'h01;
      end
   end

   a_ce_pulse_max: assert property (@(posedge CLK_I) disable iff (RST_I)
      ce_low_r < 8'(`RBSU_CE_MAX_CYC))
      else $error("chip select low too long");

   a_rst_pulse_min: assert property (@(posedge CLK_I) disable iff (RST_I)
      $rose(pin_r.rst_n) |-> ($past(rst_low_r) >= 8'(`RBSU_RST_CYC - 1)))
      else $error("device reset pulse too short");

   a_code_no_read: assert property (@(posedge CLK_I) disable iff (RST_I)
      (state_r == S_CODE) && !pin_r.ce_n |-> pin_r.rd_n && !pin_r.we_n && pin_r.dq_oe)
      else $error("code entry cycle is not a driven write");

   // Driver lets go one cycle into readout, well before the first read strobe
   a_id_no_write: assert property (@(posedge CLK_I) disable iff (RST_I)
      (state_r == S_ID) && !pin_r.ce_n |-> pin_r.we_n && !pin_r.dq_oe)
      else $error("write during identity readout");

   a_code_then_id: assert property (@(posedge CLK_I) disable iff (RST_I)
      (state_r == S_CODE) && cyc_end && (bit_r == 6'(`RBSU_LAST_BIT)) |=>
      (state_r == S_ID) && (bit_r == 6'h00))
      else $error("readout not entered after last code bit");

   a_start_restart: assert property (@(posedge CLK_I) disable iff (RST_I)
      ((state_r == S_IDLE) || (state_r == S_OPEN)) && UNLOCK_REQ_I |=>
      !unl_r && ((state_r == S_RST) || (state_r == S_DUMMY)) ##1 busy_r)
      else $error("unlock request did not restart sequence");

   a_dq_idle_read: assert property (@(posedge CLK_I) disable iff (RST_I)
      !pin_r.rd_n |-> !pin_r.dq_oe && !pin_r.ce_n)
      else $error("host drives data during read");

   a_done_unlocks: assert property (@(posedge CLK_I) disable iff (RST_I)
      done_r |-> unl_r && (state_r == S_OPEN) && $past(state_r) == S_ID)
      else $error("done without completed readout");

   c_unlock_reset: cover property (@(posedge CLK_I) disable iff (RST_I)
      $fell(pin_r.rst_n) ##[1:300] (state_r == S_CODE));
   c_unlock_done: cover property (@(posedge CLK_I) disable iff (RST_I) done_r);
   c_mem_read: cover property (@(posedge CLK_I) disable iff (RST_I) rval_r);
   c_fifo_full: cover property (@(posedge CLK_I) disable iff (RST_I)
      CMD_VALID_I && !CMD_READY_O);

endmodule : rbsu_host
`default_nettype wire

// File: verilog/rbsu_pkg.sv
// Types for the RAM bank unlock host controller
`default_nettype none
package rbsu_pkg;

   typedef enum logic [2:0] {
      S_IDLE,
      S_RST,
      S_DUMMY,
      S_CODE,
      S_ID,
      S_OPEN,
      S_MEM
   } rbsu_state_t;

   typedef struct packed {
      logic       wr;
      logic [1:0] bank;
      logic       dat;
   } rbsu_cmd_t;

   typedef struct packed {
      logic       rst_n;
      logic       ce_n;
      logic       we_n;
      logic       rd_n;
      logic [1:0] bank;
      logic       dq;
      logic       dq_oe;
   } rbsu_pins_t;

endpackage : rbsu_pkg
`default_nettype wire
